// file: adcsc_defs.svh
// Purpose: constants of the converter control block
// Assumes: byte addresses on a 32-bit avalon slave
// Notes:   none
`ifndef ADCSC_DEFS_SVH
`define ADCSC_DEFS_SVH
`define ADCSC_OFS_CTRL0    6'h00
`define ADCSC_OFS_CTRL1    6'h04
`define ADCSC_OFS_TRIG     6'h08
`define ADCSC_OFS_RESH     6'h0c
`define ADCSC_OFS_RESL     6'h10
`define ADCSC_OFS_STAT     6'h14
`define ADCSC_BIT_EN       0
`define ADCSC_BIT_GO       1
`define ADCSC_BIT_FLAG     0
`define ADCSC_BIT_IE       1
`define ADCSC_BIT_OFF      2
`define ADCSC_BIT_FMT      7
`define ADCSC_RES_BITS     10
`define ADCSC_TAD_PER_CONV 12
`define ADCSC_INSTR_CYC    4
`define ADCSC_SRC_BITS     32
`endif

// file: adcsc_far_model.sv
// Purpose: far side of the converter control: rc ticks, trigger levels, data
// Assumes: one clock, fire_i is a one-cycle request
// Notes:   trigger level stays high for seven cycles
module adcsc_far_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        fire_i,
	input  wire logic [4:0]  code_i,
	output logic             rc_tick_o,
	output logic [9:0]       data_o,
	output logic [31:0]      src_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] rc_cnt;
	logic [2:0] hold;
	// ************
	// sources
	// ************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rc_cnt <= 3'h0;
			rc_tick_o <= 1'b0;
			src_o <= 32'h0;
			hold <= 3'h0;
		end else begin
			rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
			rc_tick_o <= (rc_cnt == 3'h4);
			if (fire_i) begin
				src_o <= 32'h1 << code_i;
				hold <= 3'h6;
			end else if (hold != 3'h0) begin
				hold <= hold - 3'h1;
			end else begin
				src_o <= 32'h0;
			end
		end
	end
	assign data_o = 10'h2a5;
endmodule // adcsc_far_model

// file: adcsc_link_if.sv
// Purpose: signals between the control core, trigger and tad blocks
// Assumes: one clock
// Notes:   none
interface adcsc_link_if;
	logic [4:0] sel;
	logic       armed;
	logic       fire;
	logic [2:0] clk_sel;
	logic       run;
	logic       rc_tick;
	logic       tick;
	modport trig (input sel, input armed, output fire);
	modport tad  (input clk_sel, input run, input rc_tick, output tick);
	modport core (output sel, output armed, input fire, output clk_sel, output run,
		output rc_tick, input tick);
endinterface

// file: adcsc_pkg.sv
// Purpose: types of the converter control block
// Assumes: nothing
// Notes:   none
package adcsc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DELAY = 3'b010,
		ST_CONV  = 3'b100
	} adcsc_state_t;
	typedef logic [4:0] adcsc_sel_t;
endpackage

// file: adcsc_tad.sv
// Purpose: conversion clock tick generator
// Assumes: rc tick is a one-cycle enable from the rc oscillator
// Notes:   divider restarts whenever run drops
`include "adcsc_defs.svh"
module adcsc_tad
	import adcsc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	adcsc_link_if.tad lk
);
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic       tick;
	logic       next_tick;

	function automatic logic [5:0] div_last(input logic [2:0] cs);
		unique case (cs)
			3'b000:  div_last = 6'h01;
			3'b100:  div_last = 6'h03;
			3'b001:  div_last = 6'h07;
			3'b101:  div_last = 6'h0f;
			3'b010:  div_last = 6'h1f;
			3'b110:  div_last = 6'h3f;
			default: div_last = 6'h00;
		endcase
	endfunction

	// ************
	// divider
	// ************
	always_comb begin
		next_cnt  = 6'h00;
		next_tick = 1'b0;
		if (lk.run) begin
			if (lk.clk_sel[1:0] == 2'b11) begin
				next_tick = lk.rc_tick;
			end else if (cnt == div_last(lk.clk_sel)) begin
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt  <= 6'h00;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
	assign lk.tick = tick;

	rc_source_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(lk.run && lk.clk_sel[1:0] == 2'b11 && !lk.rc_tick) |=> !tick)
		else $error("rc mode ticked without rc tick");
endmodule // adcsc_tad

// file: adcsc_top.sv
// Purpose: converter control with sleep, wake and auto-trigger
// Assumes: avalon-mm slave, one clock, conversion data from the analog side
// Notes:   conversion takes twelve tad ticks after start
`include "adcsc_defs.svh"
module adcsc_top
	import adcsc_pkg::*;
#(
	parameter int SRC_W = `ADCSC_SRC_BITS
) (
	input  wire logic             CLK_I,
	input  wire logic             RST_N_I,
	input  wire logic [5:0]       AVS_ADDRESS_I,
	input  wire logic             AVS_READ_I,
	input  wire logic             AVS_WRITE_I,
	input  wire logic [31:0]      AVS_WRITEDATA_I,
	output logic      [31:0]      AVS_READDATA_O,
	output logic                  AVS_WAITREQUEST_O,
	input  wire logic             SLEEP_I,
	input  wire logic             RC_TICK_I,
	input  wire logic [SRC_W-1:0] TRIG_SRC_I,
	input  wire logic [9:0]       CONV_DATA_I,
	output logic                  CONV_POWERED_O,
	output logic                  CONV_BUSY_O,
	output logic                  IRQ_FLAG_O,
	output logic                  WAKE_O,
	output logic [5:0]            CHAN_SEL_O,
	output logic [2:0]            REF_SEL_O
);
	adcsc_link_if lk ();

	adcsc_trig #(
		.SRC_W (SRC_W)
	) u_trig (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.src_i   (TRIG_SRC_I),
		.lk      (lk.trig)
	);

	adcsc_tad u_tad (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.lk      (lk.tad)
	);

	// ************
	// state
	// ************
	adcsc_state_t state;
	adcsc_state_t next_state;
	logic         en;
	logic         next_en;
	logic         go_seen;
	logic [5:0]   chan;
	logic [5:0]   next_chan;
	logic [7:0]   ctrl1;
	logic [7:0]   next_ctrl1;
	logic [4:0]   tsel;
	logic [4:0]   next_tsel;
	logic         flag;
	logic         next_flag;
	logic         ie;
	logic         next_ie;
	logic         off;
	logic         next_off;
	logic         wake;
	logic         next_wake;
	logic [7:0]   resh;
	logic [7:0]   next_resh;
	logic [7:0]   resl;
	logic [7:0]   next_resl;
	logic [3:0]   tcnt;
	logic [3:0]   next_tcnt;
	logic [1:0]   dcnt;
	logic [1:0]   next_dcnt;
	logic         waitreq;
	logic         next_waitreq;
	logic [31:0]  rdata;
	logic [31:0]  next_rdata;
	logic         wr_ok;
	logic         rc;
	logic         conv_on;
	logic         start;
	logic         done;

	assign rc         = (ctrl1[5:4] == 2'b11);
	assign conv_on    = en && !off;
	assign lk.sel     = tsel;
	assign lk.armed   = conv_on && (state == ST_IDLE);
	assign lk.clk_sel = ctrl1[6:4];
	assign lk.run     = (state == ST_CONV);
	assign lk.rc_tick = RC_TICK_I;
	assign wr_ok      = AVS_WRITE_I && !waitreq;
	assign go_seen    = wr_ok && AVS_ADDRESS_I == `ADCSC_OFS_CTRL0
		&& AVS_WRITEDATA_I[`ADCSC_BIT_GO];
	assign done = (state == ST_CONV) && lk.tick
		&& tcnt == 4'(`ADCSC_TAD_PER_CONV - 1);

	always_comb begin
		next_en    = en;
		next_chan  = chan;
		next_ctrl1 = ctrl1;
		next_tsel  = tsel;
		next_ie    = ie;
		next_flag  = flag;
		if (wr_ok) begin
			unique case (AVS_ADDRESS_I)
				`ADCSC_OFS_CTRL0: begin
					next_en   = AVS_WRITEDATA_I[`ADCSC_BIT_EN];
					next_chan = AVS_WRITEDATA_I[7:2];
				end
				`ADCSC_OFS_CTRL1: next_ctrl1 = {AVS_WRITEDATA_I[7:4], 1'b0, AVS_WRITEDATA_I[2:0]};
				`ADCSC_OFS_TRIG:  next_tsel  = AVS_WRITEDATA_I[4:0];
				`ADCSC_OFS_STAT: begin
					next_ie   = AVS_WRITEDATA_I[`ADCSC_BIT_IE];
					next_flag = flag && AVS_WRITEDATA_I[`ADCSC_BIT_FLAG];
				end
				default: ;
			endcase
		end
		if (done) begin
			next_flag = 1'b1;
		end
	end

	// ************
	// conversion sequence
	// ************
	always_comb begin
		// go counts only if enable was already set before this write
		start      = (go_seen && en || lk.fire) && conv_on;
		next_state = state;
		next_tcnt  = tcnt;
		next_dcnt  = 2'h0;
		next_off   = off && SLEEP_I;
		next_wake  = 1'b0;
		next_resh  = resh;
		next_resl  = resl;
		unique case (state)
			ST_IDLE: begin
				next_tcnt = 4'h0;
				if (start) begin
					next_state = rc ? ST_DELAY : ST_CONV;
				end
			end
			ST_DELAY: begin
				next_dcnt = dcnt + 2'h1;
				if (dcnt == 2'(`ADCSC_INSTR_CYC - 1)) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (lk.tick) begin
					next_tcnt = tcnt + 4'h1;
				end
				if (done) begin
					next_state = ST_IDLE;
					if (ctrl1[`ADCSC_BIT_FMT]) begin
						next_resh = {6'h00, CONV_DATA_I[9:8]};
						next_resl = CONV_DATA_I[7:0];
					end else begin
						next_resh = CONV_DATA_I[9:2];
						next_resl = {CONV_DATA_I[1:0], 6'h00};
					end
					if (SLEEP_I) begin
						next_wake = ie;
						next_off  = !ie;
					end
				end
			end
		endcase
		if (SLEEP_I && !rc) begin
			next_state = ST_IDLE;
			next_off   = 1'b1;
		end
		if (!en) begin
			next_state = ST_IDLE;
		end
	end

	// ************
	// avalon slave
	// ************
	always_comb begin
		next_waitreq = 1'b1;
		next_rdata   = rdata;
		if ((AVS_READ_I || AVS_WRITE_I) && waitreq) begin
			next_waitreq = 1'b0;
			next_rdata   = 32'h0000_0000;
			unique case (AVS_ADDRESS_I)
				`ADCSC_OFS_CTRL0: next_rdata[7:0] = {chan, state != ST_IDLE, en};
				`ADCSC_OFS_CTRL1: next_rdata[7:0] = ctrl1;
				`ADCSC_OFS_TRIG:  next_rdata[4:0] = tsel;
				`ADCSC_OFS_RESH:  next_rdata[7:0] = resh;
				`ADCSC_OFS_RESL:  next_rdata[7:0] = resl;
				`ADCSC_OFS_STAT:  next_rdata[2:0] = {off, ie, flag};
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state   <= ST_IDLE;
			en      <= 1'b0;
			chan    <= 6'h00;
			ctrl1   <= 8'h00;
			tsel    <= 5'h00;
			flag    <= 1'b0;
			ie      <= 1'b0;
			off     <= 1'b0;
			wake    <= 1'b0;
			resh    <= 8'h00;
			resl    <= 8'h00;
			tcnt    <= 4'h0;
			dcnt    <= 2'h0;
			waitreq <= 1'b1;
			rdata   <= 32'h0000_0000;
		end else begin
			state   <= next_state;
			en      <= next_en;
			chan    <= next_chan;
			ctrl1   <= next_ctrl1;
			tsel    <= next_tsel;
			flag    <= next_flag;
			ie      <= next_ie;
			off     <= next_off;
			wake    <= next_wake;
			resh    <= next_resh;
			resl    <= next_resl;
			tcnt    <= next_tcnt;
			dcnt    <= next_dcnt;
			waitreq <= next_waitreq;
			rdata   <= next_rdata;
		end
	end

	// ************
	// outputs
	// ************
	logic       pwr;
	logic       busy;
	logic [5:0] chan_q;
	logic [2:0] ref_q;
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pwr    <= 1'b0;
			busy   <= 1'b0;
			chan_q <= 6'h00;
			ref_q  <= 3'h0;
		end else begin
			pwr    <= next_en && !next_off;
			busy   <= next_state == ST_CONV;
			chan_q <= next_chan;
			ref_q  <= next_ctrl1[2:0];
		end
	end
	assign AVS_READDATA_O    = rdata;
	assign AVS_WAITREQUEST_O = waitreq;
	assign CONV_POWERED_O    = pwr;
	assign CONV_BUSY_O       = busy;
	assign IRQ_FLAG_O        = flag;
	assign WAKE_O            = wake;
	assign CHAN_SEL_O        = chan_q;
	assign REF_SEL_O         = ref_q;

	// ************
	// checks
	// ************
	rc_delay_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(state == ST_IDLE && start && rc && !SLEEP_I && next_en)
		|=> (state == ST_DELAY)[*4] ##1 state == ST_CONV)
		else $error("rc start delay wrong");
	sleep_abort_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(SLEEP_I && !rc && state != ST_IDLE && !wr_ok)
		|=> state == ST_IDLE && off && en) else $error("sleep did not abort");
	rc_sleep_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(SLEEP_I && rc && en && state == ST_CONV && !wr_ok)
		|=> state == ST_CONV || flag) else $error("rc conversion lost in sleep");
	wake_done_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(done && SLEEP_I && ie) |=> WAKE_O ##1 !WAKE_O) else $error("no wake");
	off_done_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(done && SLEEP_I && !ie && !wr_ok) |=> off && en && !CONV_POWERED_O)
		else $error("converter not powered down");
	done_flags_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		done |=> flag && state == ST_IDLE) else $error("completion effects missing");
	first_on_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(go_seen && !en && !lk.fire && state == ST_IDLE) |=> state == ST_IDLE)
		else $error("go honoured on enabling write");
	off_ignore_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(!en && state == ST_IDLE) |=> state == ST_IDLE) else $error("start while disabled");
	trig_start_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(lk.fire && conv_on && state == ST_IDLE && next_en && !(SLEEP_I && !rc))
		|=> state != ST_IDLE) else $error("trigger did not start");
	bus_answer_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(AVS_READ_I && waitreq) |=> !AVS_WAITREQUEST_O) else $error("late answer");
	bus_write_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(AVS_WRITE_I && waitreq) |=> !AVS_WAITREQUEST_O) else $error("late write answer");
	wake_only_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!(done && SLEEP_I && ie) |=> !WAKE_O) else $error("wake without completion");
	result_load_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(done && ctrl1[`ADCSC_BIT_FMT]) |=> {resh[1:0], resl} == $past(CONV_DATA_I))
		else $error("result not loaded");
endmodule // adcsc_top

// file: adcsc_trig.sv
// Purpose: auto-trigger source sync, edge detect and select
// Assumes: sources are level signals, bit n is select code n
// Notes:   fire is one cycle
`include "adcsc_defs.svh"
module adcsc_trig
	import adcsc_pkg::*;
#(
	parameter int SRC_W = `ADCSC_SRC_BITS
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [SRC_W-1:0] src_i,
	adcsc_link_if.trig            lk
);
	logic [SRC_W-1:0] s1;
	logic [SRC_W-1:0] s2;
	logic [SRC_W-1:0] prev;
	logic             fire;
	logic             next_fire;
	logic [SRC_W-1:0] edge_v;

	// ************
	// edge and select
	// ************
	always_comb begin
		edge_v    = s2 & ~prev;
		next_fire = lk.armed && (lk.sel != 5'h00) && edge_v[lk.sel];
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1   <= '0;
			s2   <= '0;
			prev <= '0;
			fire <= 1'b0;
		end else begin
			s1   <= src_i;
			s2   <= s1;
			prev <= s2;
			fire <= next_fire;
		end
	end
	assign lk.fire = fire;

	// ************
	// checks
	// ************
	sel_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		lk.sel == 5'h00 |=> !fire) else $error("trigger fired with select zero");
	rise_fire_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(lk.armed && lk.sel != 5'h00 && s2[lk.sel] && !prev[lk.sel]) |=> fire)
		else $error("selected rising edge did not fire");
endmodule // adcsc_trig

// file: tb_adcsc.sv
// Purpose: self-checking bench of the converter control block
// Assumes: far model drives triggers, rc ticks and data
// Notes:   none
`include "adcsc_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        sleep = 1'b0;
	logic        fire = 1'b0;
	logic [4:0]  code = 5'h00;
	logic [31:0] rdata, src, q;
	logic        waitreq, rc_tick, powered, busy, flag, wake;
	logic [9:0]  data;
	logic [5:0]  chan;
	logic [2:0]  refsel;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n, i, m;
	// divider codes in order /2, /4, /8, /16, /32, /64
	logic [17:0] cs_list = {3'h6, 3'h2, 3'h5, 3'h1, 3'h4, 3'h0};
	adcsc_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(waitreq), .SLEEP_I(sleep), .RC_TICK_I(rc_tick),
		.TRIG_SRC_I(src), .CONV_DATA_I(data), .CONV_POWERED_O(powered),
		.CONV_BUSY_O(busy), .IRQ_FLAG_O(flag), .WAKE_O(wake), .CHAN_SEL_O(chan),
		.REF_SEL_O(refsel));
	adcsc_far_model far (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .code_i(code),
		.rc_tick_o(rc_tick), .data_o(data), .src_o(src));
	// ************
	// tasks
	// ************
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	task automatic results();
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic wait_on(input int s);
		n = 0;
		while (n < 500 && !((s == 0 && busy === 1'b1) || (s == 1 && wake === 1'b1)
			|| (s == 2 && flag === 1'b1))) begin
			@(posedge clk);
			n++;
		end
		check(n < 500, 1'b1);
	endtask
	task automatic wait_done();
		int k;
		k = 0;
		do begin
			bus(1'b0, `ADCSC_OFS_CTRL0, 32'h0);
			k++;
		end while (q[1] !== 1'b0 && k < 200);
		check(q[1], 1'b0);
	endtask
	task automatic pulse(input logic [4:0] c);
		@(posedge clk);
		fire <= 1'b1;
		code <= c;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	// ************
	// tests
	// ************
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(`ADCSC_OFS_STAT, 32'h0);
		bus(1'b1, `ADCSC_OFS_CTRL1, 32'h8f);
		bus(1'b1, `ADCSC_OFS_TRIG, 32'h3);
		rd_chk(`ADCSC_OFS_CTRL1, 32'h87);
		check(refsel, 3'h7);
		pulse(5'h3);
		repeat (12) @(posedge clk);
		check(busy, 1'b0);
		bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
		rd_chk(`ADCSC_OFS_CTRL0, 32'h15);
		check(chan, 6'h05);
		repeat (8) @(posedge clk);
		for (i = 0; i < 2; i++) begin
			bus(1'b1, `ADCSC_OFS_CTRL1, {24'h0, i[0], 7'h0});
			bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
			wait_done();
			check(flag, 1'b1);
			rd_chk(`ADCSC_OFS_RESH, i ? 32'h02 : 32'ha9);
			rd_chk(`ADCSC_OFS_RESL, i ? 32'ha5 : 32'h40);
			rd_chk(`ADCSC_OFS_STAT, 32'h1);
			bus(1'b1, `ADCSC_OFS_STAT, 32'h0);
			rd_chk(`ADCSC_OFS_STAT, 32'h0);
		end
		for (i = 0; i < 3; i++) begin
			bus(1'b1, `ADCSC_OFS_CTRL1, (i == 0) ? 32'h00 : (i == 1) ? 32'h30 : 32'h70);
			bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
			wait_on(0);
			check(n >= 4, i != 0);
			wait_done();
			bus(1'b1, `ADCSC_OFS_STAT, 32'h0);
		end
		for (i = 0; i < 6; i++) begin
			bus(1'b1, `ADCSC_OFS_CTRL1, {25'h0, cs_list[3*i +: 3], 4'h0});
			bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
			wait_on(0);
			m = 0;
			while (busy === 1'b1 && m < 2000) begin
				@(posedge clk);
				m++;
			end
			check(m, `ADCSC_TAD_PER_CONV * (2 << i) + 1);
			bus(1'b1, `ADCSC_OFS_STAT, 32'h0);
		end
		bus(1'b1, `ADCSC_OFS_STAT, 32'h2);
		bus(1'b1, `ADCSC_OFS_CTRL1, 32'h30);
		bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
		sleep <= 1'b1;
		wait_on(1);
		check(flag, 1'b1);
		check(powered, 1'b1);
		sleep <= 1'b0;
		bus(1'b1, `ADCSC_OFS_STAT, 32'h0);
		bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
		sleep <= 1'b1;
		wait_on(2);
		@(posedge clk);
		check(powered, 1'b0);
		rd_chk(`ADCSC_OFS_CTRL0, 32'h15);
		rd_chk(`ADCSC_OFS_STAT, 32'h5);
		sleep <= 1'b0;
		repeat (3) @(posedge clk);
		check(powered, 1'b1);
		bus(1'b1, `ADCSC_OFS_STAT, 32'h0);
		bus(1'b1, `ADCSC_OFS_CTRL1, 32'h80);
		bus(1'b1, `ADCSC_OFS_CTRL0, 32'h17);
		wait_on(0);
		sleep <= 1'b1;
		repeat (3) @(posedge clk);
		check({powered, busy}, 2'b00);
		repeat (40) @(posedge clk);
		check(flag, 1'b0);
		rd_chk(`ADCSC_OFS_CTRL0, 32'h15);
		sleep <= 1'b0;
		repeat (3) @(posedge clk);
		for (i = 1; i < 18; i++) begin
			bus(1'b1, `ADCSC_OFS_TRIG, i);
			pulse(i[4:0]);
			wait_on(0);
			repeat (8) @(posedge clk);
			pulse(i[4:0]);
			wait_done();
			repeat (10) @(posedge clk);
			check(busy, 1'b0);
			bus(1'b1, `ADCSC_OFS_STAT, 32'h0);
		end
		bus(1'b1, `ADCSC_OFS_TRIG, 32'h0);
		pulse(5'h3);
		repeat (10) @(posedge clk);
		check(busy, 1'b0);
		results();
	end
endmodule // testbench
